//--- common/iamap_pkg.sv
package iamap_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NEP  = 4;  // Endpoint slots, IDs 0..NEP-1
  localparam int NMAP = 4;  // Mapping table entries
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_USED  = 8'h08;
  localparam logic [7:0] A_TAIL  = 8'h0C;
  localparam logic [7:0] A_FEAT  = 8'h10;
  localparam logic [7:0] A_EPPR  = 8'h14;
  localparam logic [7:0] A_EPCL  = 8'h18;
  localparam logic [7:0] A_HEAD  = 8'h1C;
  localparam logic [7:0] A_DOM   = 8'h20;
  localparam logic [7:0] A_EPID  = 8'h24;
  localparam logic [7:0] A_RSV0  = 8'h28;
  localparam logic [7:0] A_RSV1  = 8'h2C;
  localparam logic [7:0] A_VST   = 8'h30;
  localparam logic [7:0] A_VEND  = 8'h34;
  localparam logic [7:0] A_PST   = 8'h38;
  localparam logic [7:0] A_FLAGS = 8'h3C;
  localparam logic [7:0] A_LEN   = 8'h40;
  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int F_INRANGE = 0;
  localparam int F_DOMRANGE = 1;
  localparam int F_MAPUNMAP = 2;
  localparam int F_BYPASS = 3;
  localparam int F_PROBE = 4;
  localparam int F_MMIO = 5;
  localparam int MF_READ = 0;
  localparam int MF_WRITE = 1;
  localparam int MF_MMIO = 2;
  localparam logic [7:0] T_ATTACH = 8'h01;
  localparam logic [7:0] T_DETACH = 8'h02;
  localparam logic [7:0] T_MAP    = 8'h03;
  localparam logic [7:0] T_UNMAP  = 8'h04;
  localparam logic [7:0] T_PROBE  = 8'h05;
  localparam logic [7:0] S_OK     = 8'h00;
  localparam logic [7:0] S_UNSUPP = 8'h02;
  localparam logic [7:0] S_INVAL  = 8'h04;
  localparam logic [7:0] S_NOENT  = 8'h06;
  localparam logic [7:0] S_NOMEM  = 8'h08;
  localparam logic [31:0] LEN_ATT = 32'h0000_0018; // Head+16+tail
  localparam logic [31:0] LEN_MAP = 32'h0000_0028; // Head+32+tail
  localparam logic [31:0] LEN_TL  = 32'h0000_0004; // Tail only
  localparam logic [31:0] LEN_HD  = 32'h0000_0004;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_DE = 2'b11;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_CLEAN = 2'b10,
    ST_DONE  = 2'b11
  } iamap_state_e;
endpackage

//--- hw/iamap_engine.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Successful request writes OK status
// - Unknown type: no write, used zero
// - Ignore head reserved; zero tail reserved
// - Attach creates missing domain
// - Shared domains, one domain per endpoint
// - Nonzero attach reserved gives invalid status
// - Missing endpoint gives not-found status
// - Adding to occupied domain is allowed
// - Reattach acts as detach then attach
// - Incompatible endpoint class gives unsupported
// - Unrejected attach always completes
// - Detached endpoint blocked, or bypass identity
// - Empty domain deleted with its mappings
// - Detach reserved ignored; mismatch gives invalid
// - Translate PA = VA - vstart + pstart
// - Flags gate read and write access
// - MMIO flag needs feature; marks no-reorder
// - Map accepted only with map feature
// - Unparsable request returns nothing written
module iamap_engine import iamap_pkg::*; (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Endpoint access lookup
  input  wire logic        xl_valid,
  input  wire logic [1:0]  xl_ep,
  input  wire logic [31:0] xl_addr,
  input  wire logic        xl_write,
  output logic             xl_done,
  output logic             xl_allow,
  output logic [31:0]      xl_pa,
  output logic             xl_mmio
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] wmask(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= A_LEN) && (a[1:0] == 2'b00);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  iamap_state_e st_q;
  logic        done_q, wrote_q;
  logic [7:0]  tail_q;
  logic [31:0] used_q;
  logic [31:0] feat_q, eppr_q, epcl_q, head_q, dom_q, epid_q;
  logic [31:0] rsv0_q, rsv1_q, vst_q, vend_q, pst_q, flags_q, len_q;
  logic        ep_att_q [NEP];
  logic [31:0] ep_dom_q [NEP];
  logic        mp_v_q   [NMAP];
  logic [31:0] mp_dom_q [NMAP];
  logic [31:0] mp_vs_q  [NMAP];
  logic [31:0] mp_ve_q  [NMAP];
  logic [31:0] mp_ps_q  [NMAP];
  logic [2:0]  mp_fl_q  [NMAP];
  logic        aw_h_q, w_h_q;
  logic [7:0]  aw_a_q;
  logic [31:0] w_d_q;
  logic [3:0]  w_s_q;
  logic        busy;
  logic        wr_do;
  logic        go;

  assign busy = (st_q != ST_IDLE);

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  // Address and data are caught in either order; answer after both
  assign s_axi_awready = !aw_h_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_h_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do = aw_h_q && w_h_q && !s_axi_bvalid;
  assign go = wr_do && (aw_a_q == A_CTRL) && w_s_q[0] && w_d_q[0] &&
              !busy;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_h_q <= 1'b0;
      w_h_q  <= 1'b0;
      aw_a_q <= 8'h00;
      w_d_q  <= 32'h0000_0000;
      w_s_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_q <= 1'b1;
        aw_a_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_q <= 1'b1;
        w_d_q <= s_axi_wdata;
        w_s_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_h_q <= 1'b0;
        w_h_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_a_q) ? RESP_OK : RESP_DE;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Request fields are frozen while a request is in flight
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      feat_q <= 32'h0000_0000;
      eppr_q <= 32'h0000_0000;
      epcl_q <= 32'h0000_0000;
      head_q <= 32'h0000_0000;
      dom_q  <= 32'h0000_0000;
      epid_q <= 32'h0000_0000;
      rsv0_q <= 32'h0000_0000;
      rsv1_q <= 32'h0000_0000;
      vst_q  <= 32'h0000_0000;
      vend_q <= 32'h0000_0000;
      pst_q  <= 32'h0000_0000;
      flags_q <= 32'h0000_0000;
      len_q  <= 32'h0000_0000;
    end else if (wr_do && !busy) begin
      case (aw_a_q)
        A_FEAT:  feat_q  <= wmask(feat_q, w_d_q, w_s_q);
        A_EPPR:  eppr_q  <= wmask(eppr_q, w_d_q, w_s_q);
        A_EPCL:  epcl_q  <= wmask(epcl_q, w_d_q, w_s_q);
        A_HEAD:  head_q  <= wmask(head_q, w_d_q, w_s_q);
        A_DOM:   dom_q   <= wmask(dom_q, w_d_q, w_s_q);
        A_EPID:  epid_q  <= wmask(epid_q, w_d_q, w_s_q);
        A_RSV0:  rsv0_q  <= wmask(rsv0_q, w_d_q, w_s_q);
        A_RSV1:  rsv1_q  <= wmask(rsv1_q, w_d_q, w_s_q);
        A_VST:   vst_q   <= wmask(vst_q, w_d_q, w_s_q);
        A_VEND:  vend_q  <= wmask(vend_q, w_d_q, w_s_q);
        A_PST:   pst_q   <= wmask(pst_q, w_d_q, w_s_q);
        A_FLAGS: flags_q <= wmask(flags_q, w_d_q, w_s_q);
        A_LEN:   len_q   <= wmask(len_q, w_d_q, w_s_q);
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped offsets answer DECERR
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OK : RESP_DE;
      case (s_axi_araddr)
        A_STAT:  s_axi_rdata <= {29'h0, wrote_q, done_q, busy};
        A_USED:  s_axi_rdata <= used_q;
        A_TAIL:  s_axi_rdata <= {24'h00_0000, tail_q};
        A_FEAT:  s_axi_rdata <= feat_q;
        A_EPPR:  s_axi_rdata <= eppr_q;
        A_EPCL:  s_axi_rdata <= epcl_q;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  logic [1:0]  ix;
  logic        ep_ok, oth, compat, free_ok;
  logic [1:0]  free_ix;
  logic        do_att, do_det, do_map, parsed, known;
  logic [7:0]  stat;

  assign ix = epid_q[1:0];

  always_comb begin
    ep_ok   = (epid_q < NEP) && eppr_q[ix];
    oth     = 1'b0;
    compat  = 1'b1;
    free_ok = 1'b0;
    free_ix = 2'd0;
    for (int j = 0; j < NEP; j++) begin
      if (j != ix && ep_att_q[j] && ep_dom_q[j] == dom_q) begin
        oth = 1'b1;
        if (epcl_q[j] != epcl_q[ix]) begin
          compat = 1'b0;
        end
      end
    end
    for (int i = NMAP - 1; i >= 0; i--) begin
      if (!mp_v_q[i]) begin
        free_ok = 1'b1;
        free_ix = i[1:0];
      end
    end
  end

  // Head reserved bytes are never looked at; only the type byte
  always_comb begin
    do_att = 1'b0;
    do_det = 1'b0;
    do_map = 1'b0;
    stat   = S_OK;
    known  = 1'b1;
    parsed = 1'b1;
    case (head_q[7:0])
      T_ATTACH: begin
        parsed = (len_q >= LEN_ATT);
        if ((rsv0_q | rsv1_q) != 32'h0000_0000) begin
          stat = S_INVAL;
        end else if (!ep_ok) begin
          stat = S_NOENT;
        end else if (oth && !compat) begin
          stat = S_UNSUPP;
        end else begin
          do_att = 1'b1;
        end
      end
      T_DETACH: begin
        parsed = (len_q >= LEN_ATT);
        if (!ep_ok) begin
          stat = S_NOENT;
        end else if (!ep_att_q[ix] || ep_dom_q[ix] != dom_q) begin
          stat = S_INVAL;
        end else begin
          do_det = 1'b1;
        end
      end
      T_MAP: begin
        parsed = (len_q >= LEN_MAP);
        if (!feat_q[F_MAPUNMAP]) begin
          stat = S_UNSUPP;
        end else if (flags_q[MF_MMIO] && !feat_q[F_MMIO]) begin
          stat = S_INVAL;
        end else if (!free_ok) begin
          stat = S_NOMEM;
        end else begin
          do_map = 1'b1;
        end
      end
      T_UNMAP, T_PROBE: begin
        parsed = (len_q >= LEN_HD + LEN_TL);
        stat = S_UNSUPP;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Completion is flagged one state after the tables settle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE:  st_q <= go ? ST_EXEC : ST_IDLE;
        ST_EXEC:  st_q <= ST_CLEAN;
        ST_CLEAN: st_q <= ST_DONE;
        ST_DONE:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // Outcome: unparsable or unknown requests leave the tail alone
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q  <= 1'b0;
      wrote_q <= 1'b0;
      tail_q  <= 8'h00;
      used_q  <= 32'h0000_0000;
    end else if (st_q == ST_EXEC) begin
      if (!known || !parsed) begin
        wrote_q <= 1'b0;
        used_q  <= 32'h0000_0000;
      end else begin
        wrote_q <= 1'b1;
        tail_q  <= stat;
        used_q  <= LEN_TL;
      end
    end else if (st_q == ST_DONE) begin
      done_q <= 1'b1;
    end else if (go) begin
      done_q <= 1'b0;
    end
  end

  // Endpoint table; an endpoint holds one domain at a time
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int j = 0; j < NEP; j++) begin
        ep_att_q[j] <= 1'b0;
        ep_dom_q[j] <= 32'h0000_0000;
      end
    end else if (st_q == ST_EXEC && known && parsed) begin
      if (do_att) begin
        ep_att_q[ix] <= 1'b1;
        ep_dom_q[ix] <= dom_q;
      end else if (do_det) begin
        ep_att_q[ix] <= 1'b0;
      end
    end
  end

  // Mapping table; a domain with no member loses all mappings
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NMAP; i++) begin
        mp_v_q[i]   <= 1'b0;
        mp_dom_q[i] <= 32'h0000_0000;
        mp_vs_q[i]  <= 32'h0000_0000;
        mp_ve_q[i]  <= 32'h0000_0000;
        mp_ps_q[i]  <= 32'h0000_0000;
        mp_fl_q[i]  <= 3'b000;
      end
    end else if (st_q == ST_EXEC && known && parsed && do_map) begin
      mp_v_q[free_ix]   <= 1'b1;
      mp_dom_q[free_ix] <= dom_q;
      mp_vs_q[free_ix]  <= vst_q;
      mp_ve_q[free_ix]  <= vend_q;
      mp_ps_q[free_ix]  <= pst_q;
      mp_fl_q[free_ix]  <= flags_q[2:0];
    end else if (st_q == ST_CLEAN) begin
      for (int i = 0; i < NMAP; i++) begin
        logic live;
        live = 1'b0;
        for (int j = 0; j < NEP; j++) begin
          if (ep_att_q[j] && ep_dom_q[j] == mp_dom_q[i]) begin
            live = 1'b1;
          end
        end
        if (!live) begin
          mp_v_q[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Access lookup
  // ------------------------------------------------------------
  // One lookup per cycle, answered at the next edge
  logic        hit, perm, hmmio;
  logic [31:0] hpa;

  always_comb begin
    hit   = 1'b0;
    perm  = 1'b0;
    hmmio = 1'b0;
    hpa   = 32'h0000_0000;
    for (int i = NMAP - 1; i >= 0; i--) begin
      if (mp_v_q[i] && mp_dom_q[i] == ep_dom_q[xl_ep] &&
          xl_addr >= mp_vs_q[i] && xl_addr <= mp_ve_q[i]) begin
        hit   = 1'b1;
        perm  = xl_write ? mp_fl_q[i][MF_WRITE]
                         : mp_fl_q[i][MF_READ];
        hmmio = mp_fl_q[i][MF_MMIO];
        hpa   = xl_addr - mp_vs_q[i] + mp_ps_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xl_done  <= 1'b0;
      xl_allow <= 1'b0;
      xl_pa    <= 32'h0000_0000;
      xl_mmio  <= 1'b0;
    end else begin
      xl_done <= xl_valid;
      if (!xl_valid) begin
        xl_allow <= 1'b0;
        xl_mmio  <= 1'b0;
      end else if (!eppr_q[xl_ep]) begin
        xl_allow <= 1'b0;
        xl_mmio  <= 1'b0;
      end else if (!ep_att_q[xl_ep]) begin
        xl_allow <= feat_q[F_BYPASS];
        xl_pa    <= xl_addr;
        xl_mmio  <= 1'b0;
      end else begin
        xl_allow <= hit && perm;
        xl_pa    <= hpa;
        xl_mmio  <= hit && hmmio;
      end
    end
  end

endmodule

//--- verification/iamap_chk.sv
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module iamap_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Lookup
  input wire logic        xl_valid,
  input wire logic        xl_done,
  input wire logic        xl_allow,
  input wire logic        xl_mmio
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Both write halves taken on one edge
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response offered but not yet taken
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  AST_B_AFTER_W:
    assert property (s_wtake |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD:
    assert property (s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_AR_BLOCK:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_W_BLOCK:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_XL_DONE:
    assert property (xl_valid |=> xl_done)
    else $error("lookup answer missing");
  AST_XL_QUIET:
    assert property (!xl_valid |=> !xl_done && !xl_allow)
    else $error("lookup answer without request");
  AST_XL_ALLOW:
    assert property (xl_allow |-> xl_done)
    else $error("allow outside answer");
  AST_XL_MMIO:
    assert property (xl_mmio |-> xl_done)
    else $error("mmio mark outside answer");
endmodule

bind iamap_engine iamap_chk iamap_chk_inst (
  .ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .xl_valid, .xl_done, .xl_allow, .xl_mmio
);

//--- verification/iamap_drv.sv
`timescale 1ns/1ps
// Guest driver model: posts requests as register bus master
module iamap_drv import iamap_pkg::*; (
  // Clock
  input  wire logic        ref_clk,
  // Write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic failed;
  // Idle bus at time zero
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    failed = 1'b0;
  end
  // Ready is raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_wready) s_axi_wdata <= ~d;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Post one request; domains and ranges stay inside limits
  task automatic req(input logic [7:0] typ, input logic [23:0] junk,
                     input logic [31:0] len, output logic [31:0] used,
                     output logic [31:0] tl, output logic [31:0] st);
    logic [1:0] r;
    wr(A_HEAD, {junk, typ}, r);
    wr(A_LEN, len, r);
    wr(A_CTRL, 32'h0000_0001, r);
    st = 32'h0;
    while (st[1] !== 1'b1) rd(A_STAT, st, r);
    rd(A_USED, used, r);
    rd(A_TAIL, tl, r);
    failed = (used == 32'h0);
  endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] %s expected %h seen %h", n, e, a); \
  end end
module testbench import iamap_pkg::*;;
  logic        ref_clk, sys_rst, xl_valid, xl_write;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, xl_done, xl_allow, xl_mmio;
  logic [1:0]  s_axi_bresp, s_axi_rresp, xl_ep;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, xl_addr, xl_pa;
  int          miscompares = 0;
  int          n_compared = 0;
  iamap_engine iamap_engine_inst (
    .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .xl_valid, .xl_ep, .xl_addr,
    .xl_write, .xl_done, .xl_allow, .xl_pa, .xl_mmio
  );
  iamap_drv iamap_drv_inst (
    .ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  // ----------
  // Helpers
  // ----------
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    iamap_drv_inst.wr(a, d, r);
  endtask
  // Attach or detach with the expected status
  task automatic ad(input logic [7:0] t, input logic [23:0] j,
                    input logic [31:0] dom, ep, rsv, input logic [7:0] e);
    logic [31:0] u, tl, st;
    w(A_DOM, dom);
    w(A_EPID, ep);
    w(A_RSV0, 32'h0);
    w(A_RSV1, rsv);
    iamap_drv_inst.req(t, j, LEN_ATT, u, tl, st);
    `CHK("tail", {24'h0, e}, tl)
    `CHK("used", LEN_TL, u)
  endtask
  task automatic mp(input logic [31:0] vs, ve, ps, fl,
                    input logic [7:0] e);
    logic [31:0] u, tl, st;
    w(A_DOM, 32'h1);
    w(A_VST, vs);
    w(A_VEND, ve);
    w(A_PST, ps);
    w(A_FLAGS, fl);
    iamap_drv_inst.req(T_MAP, 24'h0, LEN_MAP, u, tl, st);
    `CHK("map tail", {24'h0, e}, tl)
  endtask
  // Answer is read at the edge where the design still shows it
  task automatic lk(input logic [1:0] ep, input logic [31:0] va,
                    input logic wt, al, input logic [31:0] pa,
                    input logic mm);
    xl_ep <= ep;
    xl_addr <= va;
    xl_write <= wt;
    xl_valid <= 1'b1;
    @(posedge ref_clk);
    xl_valid <= 1'b0;
    @(posedge ref_clk);
    `CHK("done", 1'b1, xl_done)
    `CHK("allow", al, xl_allow)
    if (al) `CHK("pa", pa, xl_pa)
    if (al) `CHK("mmio", mm, xl_mmio)
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reg;
    logic [31:0] d;
    logic [1:0]  rr;
    iamap_drv_inst.rd(A_STAT, d, rr);
    `CHK("stat", 32'h0, d)
    iamap_drv_inst.rd(8'h44, d, rr);
    `CHK("bad read", RESP_DE, rr)
    iamap_drv_inst.wr(8'h44, 32'h1, rr);
    `CHK("bad write", RESP_DE, rr)
    w(A_EPPR, 32'h0000_0007);
    w(A_EPCL, 32'h0000_0002);
    iamap_drv_inst.rd(A_EPPR, d, rr);
    `CHK("eppr", 32'h0000_0007, d)
    lk(0, 32'h1000, 1'b0, 1'b0, 32'h0, 1'b0);
    $display("register test done");
  endtask
  task automatic t_attach;
    w(A_FEAT, 32'h0000_0004);
    ad(T_ATTACH, 24'hAB_CDEF, 1, 0, 0, S_OK);
    ad(T_ATTACH, 24'h0, 1, 2, 1, S_INVAL);
    ad(T_ATTACH, 24'h0, 1, 3, 0, S_NOENT);
    ad(T_ATTACH, 24'h0, 1, 1, 0, S_UNSUPP);
    ad(T_ATTACH, 24'h0, 1, 2, 0, S_OK);
    $display("attach test done");
  endtask
  task automatic t_map;
    w(A_FEAT, 32'h0);
    mp(32'h1000, 32'h1FFF, 32'hA000, 32'h1, S_UNSUPP);
    w(A_FEAT, 32'h0000_0004);
    mp(32'h1000, 32'h1FFF, 32'hA000, 32'h1, S_OK);
    mp(32'h4000, 32'h4FFF, 32'h8000, 32'h7, S_INVAL);
    w(A_FEAT, 32'h0000_0024);
    mp(32'h4000, 32'h4FFF, 32'h8000, 32'h7, S_OK);
    mp(32'h6000, 32'h6FFF, 32'hC000, 32'h1, S_OK);
    mp(32'h7000, 32'h7FFF, 32'hD000, 32'h1, S_OK);
    mp(32'h9000, 32'h9FFF, 32'hE000, 32'h1, S_NOMEM);
    lk(0, 32'h1800, 1'b0, 1'b1, 32'hA800, 1'b0);
    lk(2, 32'h1000, 1'b0, 1'b1, 32'hA000, 1'b0);
    lk(0, 32'h1FFF, 1'b0, 1'b1, 32'hAFFF, 1'b0);
    lk(0, 32'h2000, 1'b0, 1'b0, 32'h0, 1'b0);
    lk(0, 32'h1800, 1'b1, 1'b0, 32'h0, 1'b0);
    lk(2, 32'h4004, 1'b1, 1'b1, 32'h8004, 1'b1);
    lk(1, 32'h1800, 1'b0, 1'b0, 32'h0, 1'b0);
    $display("map test done");
  endtask
  task automatic t_detach;
    ad(T_ATTACH, 24'h0, 2, 0, 0, S_OK);
    lk(0, 32'h1800, 1'b0, 1'b0, 32'h0, 1'b0);
    ad(T_DETACH, 24'h0, 3, 2, 0, S_INVAL);
    ad(T_DETACH, 24'h0, 1, 2, 32'hFF, S_OK);
    lk(2, 32'h1800, 1'b0, 1'b0, 32'h0, 1'b0);
    w(A_FEAT, 32'h0000_002C);
    lk(2, 32'h1800, 1'b1, 1'b1, 32'h1800, 1'b0);
    ad(T_ATTACH, 24'h0, 1, 1, 0, S_OK);
    lk(1, 32'h1800, 1'b0, 1'b0, 32'h0, 1'b0);
    $display("detach test done");
  endtask
  task automatic t_bad;
    logic [31:0] u, tl, st;
    ad(T_DETACH, 24'h0, 1, 3, 0, S_NOENT);
    iamap_drv_inst.req(8'h07, 24'h0, LEN_ATT, u, tl, st);
    `CHK("unknown used", 32'h0, u)
    `CHK("unknown tail", {24'h0, S_NOENT}, tl)
    `CHK("unknown wrote", 1'b0, st[2])
    `CHK("failed", 1'b1, iamap_drv_inst.failed)
    iamap_drv_inst.req(T_ATTACH, 24'h0, 32'h8, u, tl, st);
    `CHK("short used", 32'h0, u)
    for (int k = 4; k < 6; k++) begin
      iamap_drv_inst.req(k[7:0], 24'h0, LEN_MAP, u, tl, st);
      `CHK("other tail", {24'h0, S_UNSUPP}, tl)
    end
    $display("error test done");
  endtask
  // Watchdog sized well above the expected run of under a thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    complete_run;
  end
  // Reset, then the scenarios in order
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    xl_valid = 1'b0;
    xl_ep = 2'h0;
    xl_addr = 32'h0;
    xl_write = 1'b0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reg;
    t_attach;
    t_map;
    t_detach;
    t_bad;
    complete_run;
  end
endmodule
